/* File: rtl/tsm_consts.svh */
`ifndef TSM_CONSTS_SVH
`define TSM_CONSTS_SVH
// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define TSM_CTL_OFF     12'h000
`define TSM_SMC_OFF     12'h008
`define TSM_CNT_OFF     12'h00c
// ****************************************
// Field positions and reset values
// ****************************************
`define TSM_SF_LSB      0
`define TSM_TS_LSB      4
`define TSM_MSM_BIT     7
`define TSM_FC_LSB      8
`define TSM_RUN_BIT     0
`define TSM_FDIV_LSB    8
`define TSM_SMC_MASK    16'h0ff7
`define TSM_SMC_RST     16'h0000
`define TSM_CNT_RST     16'h0000
// ****************************************
// Timing
// ****************************************
`define TSM_CLK_NS      25
`define TSM_APB_WAIT    1
`endif

/* File: rtl/tsm_pkg.sv */
`default_nettype none
package tsm_pkg;
  // Slave function encodings
  typedef enum logic [2:0] {
    SF_OFF   = 3'b000,
    SF_ENC1  = 3'b001,
    SF_ENC2  = 3'b010,
    SF_ENC3  = 3'b011,
    SF_RESET = 3'b100,
    SF_GATED = 3'b101,
    SF_TRIG  = 3'b110,
    SF_EXT1  = 3'b111
  } tsm_sf_t;
  // APB request bundle
  typedef struct packed {
    logic        sel;
    logic        en;
    logic        wr;
    logic [11:0] addr;
    logic [31:0] wdata;
  } tsm_apb_req_t;
  // Top-level state
  typedef struct packed {
    logic [15:0] smc;
    logic        run;
    logic [1:0]  fdiv;
    logic [15:0] cnt;
    logic        trig_prev;
    logic        rise_dly;
    logic        upd;
    logic        sel_trig;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } tsm_top_st_t;
  // Filter state
  typedef struct packed {
    logic [7:0] div_cnt;
    logic [3:0] same_cnt;
    logic       out;
  } tsm_flt_st_t;
endpackage
`default_nettype wire

/* File: rtl/tsm_etr_filter.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tsm_consts.svh"
module tsm_etr_filter
  import tsm_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       raw_i,
  input  wire logic [3:0] cfg_i,
  input  wire logic [1:0] fdiv_i,
  output logic            filt_o
);
  tsm_flt_st_t st;
  tsm_flt_st_t next_st;
  logic [9:0]  len;
  logic [7:0]  period;
  logic [3:0]  need;
  logic        smp_en;

  // Code to {divisor, sample count}; code 0 is a plain one-sample pass
  function automatic logic [9:0] flt_len(input logic [3:0] c);
    case (c)
      4'h0: flt_len = {6'd1, 4'd1};
      4'h1: flt_len = {6'd1, 4'd2};
      4'h2: flt_len = {6'd1, 4'd4};
      4'h3: flt_len = {6'd1, 4'd8};
      4'h4: flt_len = {6'd2, 4'd6};
      4'h5: flt_len = {6'd2, 4'd8};
      4'h6: flt_len = {6'd4, 4'd6};
      4'h7: flt_len = {6'd4, 4'd8};
      4'h8: flt_len = {6'd8, 4'd6};
      4'h9: flt_len = {6'd8, 4'd8};
      4'ha: flt_len = {6'd16, 4'd5};
      4'hb: flt_len = {6'd16, 4'd6};
      4'hc: flt_len = {6'd16, 4'd8};
      4'hd: flt_len = {6'd32, 4'd5};
      4'he: flt_len = {6'd32, 4'd6};
      default: flt_len = {6'd32, 4'd8};
    endcase
  endfunction

  // Sample period in timer clocks; reserved divide code acts as x4
  always_comb begin
    len    = flt_len(cfg_i);
    period = {2'b00, len[9:4]} << ((fdiv_i == 2'b11) ? 2'd2 : fdiv_i);
    need   = len[3:0];
    smp_en = (st.div_cnt >= period - 8'h1);
  end

  // Level changes only after N agreeing samples in a row
  always_comb begin
    next_st = st;
    next_st.div_cnt = smp_en ? 8'h00 : st.div_cnt + 8'h1;
    if (smp_en) begin
      if (raw_i == st.out) begin
        next_st.same_cnt = 4'h0;
      end else if (st.same_cnt + 4'h1 >= need) begin
        next_st.out      = raw_i;
        next_st.same_cnt = 4'h0;
      end else begin
        next_st.same_cnt = st.same_cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign filt_o = st.out;

  chk_filt_bypass: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (cfg_i == 4'h0 && smp_en) |=> filt_o == $past(raw_i))
    else $error("unfiltered trigger did not follow sample");
endmodule
`default_nettype wire

/* File: rtl/tsm_quad_step.sv */
`timescale 1ns/1ps
`default_nettype none
module tsm_quad_step
  import tsm_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [2:0] mode_i,
  input  wire logic       a_i,
  input  wire logic       b_i,
  output logic            step_o,
  output logic            up_o
);
  logic [1:0] prev;
  logic       ea;
  logic       eb;

  // Previous channel levels for edge finding
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      prev <= 2'b00;
    end else begin
      prev <= {a_i, b_i};
    end
  end

  // Direction from the level of the other channel
  always_comb begin
    ea     = a_i ^ prev[1];
    eb     = b_i ^ prev[0];
    step_o = 1'b0;
    up_o   = 1'b0;
    case (mode_i)
      SF_ENC1: begin
        step_o = eb;
        up_o   = b_i ~^ a_i;
      end
      SF_ENC2: begin
        step_o = ea;
        up_o   = a_i ^ b_i;
      end
      SF_ENC3: begin
        step_o = ea | eb;
        up_o   = ea ? (a_i ^ b_i) : (b_i ~^ a_i);
      end
      default: begin
        step_o = 1'b0;
      end
    endcase
  end

  chk_enc1_dir: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (mode_i == SF_ENC1 && a_i && $rose(b_i)) |-> step_o && up_o)
    else $error("encoder mode 1 direction wrong");
endmodule
`default_nettype wire

/* File: rtl/tsm_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tsm_consts.svh"
module tsm_top
  import tsm_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input  wire logic              CLOCK_I,
  input  wire logic              RESET_N_I,
  input  wire logic              PSEL_I,
  input  wire logic              PENABLE_I,
  input  wire logic              PWRITE_I,
  input  wire logic [ADDR_W-1:0] PADDR_I,
  input  wire logic [31:0]       PWDATA_I,
  output logic      [31:0]       PRDATA_O,
  output logic                   PREADY_O,
  output logic                   PSLVERR_O,
  input  wire logic [3:0]        INTERNAL_TRIGGER_I,
  input  wire logic              CH1_EDGE_DETECT_I,
  input  wire logic              CH1_FILTERED_INPUT_I,
  input  wire logic              CH2_FILTERED_INPUT_I,
  input  wire logic              EXT_TRIGGER_I,
  output logic      [15:0]       COUNT_O,
  output logic                   COUNTER_RUN_ENABLE_O,
  output logic                   UPDATE_EVENT_O,
  output logic                   SELECTED_TRIGGER_INPUT_O,
  output logic                   FILTERED_EXT_TRIGGER_O,
  output logic                   MASTER_SLAVE_SYNC_ENABLE_O
);
  // ****************************************
  // Elaboration checks
  // ****************************************
  if (ADDR_W < 4 || ADDR_W > 12) begin : g_bad_addr
    $error("ADDR_W must lie between 4 and 12");
  end

  // ****************************************
  // Declarations
  // ****************************************
  tsm_top_st_t  st;
  tsm_top_st_t  next_st;
  tsm_apb_req_t req;
  tsm_sf_t      sf;
  logic [2:0]   trg_sel;
  logic         msm;
  logic         filt_etr;
  logic         trig;
  logic         rise_raw;
  logic         rise;
  logic         lvl;
  logic         enc_step;
  logic         enc_up;
  logic         acc;

  // Counter step, shared by every counting mode
  function automatic logic [15:0] cnt_step(input logic [15:0] c, input logic up);
    cnt_step = up ? c + 16'h0001 : c - 16'h0001;
  endfunction

  // Trigger source multiplexer
  function automatic logic trig_mux(input logic [2:0] s, input logic [3:0] itr,
                                    input logic ed, input logic c1,
                                    input logic c2, input logic etr);
    case (s)
      3'b100:  trig_mux = ed;
      3'b101:  trig_mux = c1;
      3'b110:  trig_mux = c2;
      3'b111:  trig_mux = etr;
      default: trig_mux = itr[s[1:0]];
    endcase
  endfunction

  // ****************************************
  // Sub-blocks
  // ****************************************
  // External trigger filter on the divided sample clock
  tsm_etr_filter u_filter (
    .clk_i   (CLOCK_I),
    .rst_n_i (RESET_N_I),
    .raw_i   (EXT_TRIGGER_I),
    .cfg_i   (st.smc[`TSM_FC_LSB +: 4]),
    .fdiv_i  (st.fdiv),
    .filt_o  (filt_etr)
  );

  // Quadrature step decoder for encoder functions
  tsm_quad_step u_quad (
    .clk_i   (CLOCK_I),
    .rst_n_i (RESET_N_I),
    .mode_i  (st.smc[`TSM_SF_LSB +: 3]),
    .a_i     (CH1_FILTERED_INPUT_I),
    .b_i     (CH2_FILTERED_INPUT_I),
    .step_o  (enc_step),
    .up_o    (enc_up)
  );

  // ****************************************
  // Trigger path
  // ****************************************
  // Field decode and edge finding on the selected source
  always_comb begin
    req      = '{sel: PSEL_I, en: PENABLE_I, wr: PWRITE_I,
                 addr: 12'(PADDR_I), wdata: PWDATA_I};
    sf       = tsm_sf_t'(st.smc[`TSM_SF_LSB +: 3]);
    trg_sel  = st.smc[`TSM_TS_LSB +: 3];
    msm      = st.smc[`TSM_MSM_BIT];
    trig     = trig_mux(trg_sel, INTERNAL_TRIGGER_I, CH1_EDGE_DETECT_I,
                        CH1_FILTERED_INPUT_I, CH2_FILTERED_INPUT_I, filt_etr);
    rise_raw = trig & ~st.trig_prev;
    // Sync delays the slave's reaction one clock to line up with its master
    rise     = msm ? st.rise_dly : rise_raw;
    lvl      = msm ? st.trig_prev : trig;
    acc      = req.sel & req.en & st.pready;
  end

  // ****************************************
  // Next-state logic
  // ****************************************
  // Bus, register writes, then counter behaviour per slave function
  always_comb begin
    next_st           = st;
    next_st.trig_prev = trig;
    next_st.rise_dly  = rise_raw;
    next_st.sel_trig  = trig;
    next_st.upd       = 1'b0;
    // One wait state keeps every bus output on a flop
    next_st.pready    = req.sel & req.en & ~st.pready;
    next_st.pslverr   = 1'b0;
    if (req.sel & req.en & ~st.pready) begin
      next_st.prdata = 32'h0000_0000;
      case (req.addr)
        `TSM_CTL_OFF: next_st.prdata = {22'h0, st.fdiv, 7'h0, st.run};
        `TSM_SMC_OFF: next_st.prdata = {16'h0, st.smc};
        `TSM_CNT_OFF: next_st.prdata = {16'h0, st.cnt};
        default:      next_st.pslverr = 1'b1;
      endcase
    end
    // Writes land only on the edge that completes the access
    if (acc & req.wr) begin
      case (req.addr)
        `TSM_CTL_OFF: begin
          next_st.run = req.wdata[`TSM_RUN_BIT];
          next_st.fdiv = req.wdata[`TSM_FDIV_LSB +: 2];
        end
        // Reserved bits 3 and 15:12 stay zero
        `TSM_SMC_OFF: next_st.smc = req.wdata[15:0] & `TSM_SMC_MASK;
        default: next_st.run = st.run;
      endcase
    end
    case (sf)
      SF_OFF: begin
        if (st.run) next_st.cnt = cnt_step(st.cnt, 1'b1);
      end
      SF_ENC1, SF_ENC2, SF_ENC3: begin
        if (st.run && enc_step) next_st.cnt = cnt_step(st.cnt, enc_up);
      end
      SF_RESET: begin
        if (rise) begin
          next_st.cnt = `TSM_CNT_RST;
          next_st.upd = 1'b1;
        end else if (st.run) begin
          next_st.cnt = cnt_step(st.cnt, 1'b1);
        end
      end
      SF_GATED: begin
        if (st.run && lvl) next_st.cnt = cnt_step(st.cnt, 1'b1);
      end
      SF_TRIG: begin
        // Hardware set wins over a software clear in the same cycle
        if (rise) next_st.run = 1'b1;
        if (st.run) next_st.cnt = cnt_step(st.cnt, 1'b1);
      end
      SF_EXT1: begin
        if (st.run && rise) next_st.cnt = cnt_step(st.cnt, 1'b1);
      end
      default: next_st.cnt = st.cnt;
    endcase
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      st     <= '0;
      st.smc <= `TSM_SMC_RST;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from state flops
  assign PRDATA_O                   = st.prdata;
  assign PREADY_O                   = st.pready;
  assign PSLVERR_O                  = st.pslverr;
  assign COUNT_O                    = st.cnt;
  assign COUNTER_RUN_ENABLE_O       = st.run;
  assign UPDATE_EVENT_O             = st.upd;
  assign SELECTED_TRIGGER_INPUT_O   = st.sel_trig;
  assign FILTERED_EXT_TRIGGER_O     = filt_etr;
  assign MASTER_SLAVE_SYNC_ENABLE_O = st.smc[`TSM_MSM_BIT];

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RESET_N_I);

  sequence s_reset_edge;
    sf == SF_RESET && rise && !(acc && req.wr);
  endsequence
  sequence s_cleared;
    COUNT_O == 16'h0000 && UPDATE_EVENT_O;
  endsequence

  chk_reset_clears: assert property (s_reset_edge |=> s_cleared)
    else $error("reset edge did not clear counter");
  chk_gate_holds: assert property (sf == SF_GATED && !lvl |=> $stable(COUNT_O))
    else $error("gated counter moved while low");
  chk_gate_runs: assert property (sf == SF_GATED && lvl && st.run
    |=> COUNT_O == 16'($past(COUNT_O) + 16'h0001))
    else $error("gated counter stalled while high");
  chk_trig_starts: assert property (sf == SF_TRIG && rise |=> COUNTER_RUN_ENABLE_O)
    else $error("trigger edge did not start counter");
  chk_ext_clock: assert property (sf == SF_EXT1 && !rise |=> $stable(COUNT_O))
    else $error("external clock mode counted without edge");
  chk_free_run: assert property (sf == SF_OFF && st.run
    |=> COUNT_O == 16'($past(COUNT_O) + 16'h0001))
    else $error("idle slave counter did not advance");
  chk_etr_select: assert property (trg_sel == 3'b111
    |=> SELECTED_TRIGGER_INPUT_O == $past(filt_etr))
    else $error("filtered trigger not selected");
  chk_sync_delay: assert property (msm && sf == SF_TRIG && rise_raw && !st.run
    && !(acc && req.wr) |=> !COUNTER_RUN_ENABLE_O ##1 COUNTER_RUN_ENABLE_O)
    else $error("synchronised start not delayed one clock");

  // Update strobe stands for a single clock
  chk_upd_single: assert property (UPDATE_EVENT_O
    |=> !UPDATE_EVENT_O)
    else $error("update event longer than one clock");

  // With run clear an idle slave leaves the count alone
  chk_off_hold: assert property (sf == SF_OFF && !st.run
    |=> $stable(COUNT_O))
    else $error("stopped counter moved");

  // Encoder functions move the count only on a channel edge
  chk_enc_hold: assert property (sf inside {SF_ENC1, SF_ENC2, SF_ENC3} && !enc_step
    |=> $stable(COUNT_O))
    else $error("encoder count moved without edge");

  // Channel 2 rising while channel 1 is low counts down
  chk_enc1_down: assert property (sf == SF_ENC1 && st.run && !CH1_FILTERED_INPUT_I
    && $rose(CH2_FILTERED_INPUT_I) |=> COUNT_O == 16'($past(COUNT_O) - 16'h0001))
    else $error("encoder mode 1 did not count down");

  // Channel 1 rising while channel 2 is low counts up
  chk_enc2_up: assert property (sf == SF_ENC2 && st.run && !CH2_FILTERED_INPUT_I
    && $rose(CH1_FILTERED_INPUT_I) |=> COUNT_O == 16'($past(COUNT_O) + 16'h0001))
    else $error("encoder mode 2 did not count up");

  // Each trigger edge in external clock mode is one count
  chk_ext_step: assert property (sf == SF_EXT1 && st.run && rise
    |=> COUNT_O == 16'($past(COUNT_O) + 16'h0001))
    else $error("external clock edge not counted");

  // Internal trigger 0 reaches the selected trigger a clock later
  chk_internal_trigger_0_select: assert property (trg_sel == 3'b000
    |=> SELECTED_TRIGGER_INPUT_O == $past(INTERNAL_TRIGGER_I[0]))
    else $error("internal trigger 0 not selected");

  // Channel 1 filtered input reaches the selected trigger a clock later
  chk_ch1_select: assert property (trg_sel == 3'b101
    |=> SELECTED_TRIGGER_INPUT_O == $past(CH1_FILTERED_INPUT_I))
    else $error("channel 1 input not selected");

  // Run bit set by a trigger stays set until software clears it
  chk_trig_keeps: assert property (sf == SF_TRIG && st.run && !(acc && req.wr)
    |=> COUNTER_RUN_ENABLE_O)
    else $error("trigger mode run bit dropped");
endmodule
`default_nettype wire

/* File: test/tsm_far_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Far side: other timers and input pins
// ****************************************
module tsm_far_model
  import tsm_pkg::*;
#(
  parameter int LAG = 1
)
(
  input  wire logic       clk_i,
  input  wire logic [7:0] lvl_i,
  output logic      [3:0] itr_o,
  output logic            ed_o,
  output logic            c1_o,
  output logic            c2_o,
  output logic            ext_o
);
  logic [7:0] pipe [LAG];
  // Sources are synchronous, so levels move only just after an edge
  always_ff @(posedge clk_i) begin
    pipe[0] <= lvl_i;
    for (int i = 1; i < LAG; i++) begin
      pipe[i] <= pipe[i-1];
    end
  end
  // Larger LAG gives a slow source
  assign {ext_o, c2_o, c1_o, ed_o, itr_o} = pipe[LAG-1];
endmodule
`default_nettype wire

/* File: test/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tsm_consts.svh"
module tb_top;
  import tsm_pkg::*;
  logic        clk, rst_n, psel, pen, pwr, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r32;
  logic [3:0]  itr;
  logic        ed, c1, c2, ext, run, upd, trg, fext, msm, e1;
  logic [15:0] cnt, c0;
  logic [7:0]  lvl;
  int          n_mismatch, compares, n, lat[2];
  int          dv[10] = '{1, 1, 1, 1, 2, 2, 4, 4, 8, 8};
  int          nn[10] = '{1, 2, 4, 8, 6, 8, 6, 8, 6, 8};
  logic [7:0]  fw[4] = '{8'h20, 8'h60, 8'h40, 8'h00};
  logic [7:0]  bk[4] = '{8'h40, 8'h60, 8'h20, 8'h00};
  int          ex[4] = '{0, 2, 2, 4};

  tsm_top u_dut (
    .CLOCK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .INTERNAL_TRIGGER_I(itr),
    .CH1_EDGE_DETECT_I(ed), .CH1_FILTERED_INPUT_I(c1), .CH2_FILTERED_INPUT_I(c2),
    .EXT_TRIGGER_I(ext), .COUNT_O(cnt), .COUNTER_RUN_ENABLE_O(run),
    .UPDATE_EVENT_O(upd), .SELECTED_TRIGGER_INPUT_O(trg),
    .FILTERED_EXT_TRIGGER_O(fext), .MASTER_SLAVE_SYNC_ENABLE_O(msm));

  tsm_far_model u_far (
    .clk_i(clk), .lvl_i(lvl), .itr_o(itr), .ed_o(ed), .c1_o(c1),
    .c2_o(c2), .ext_o(ext));

  // 40 MHz timer clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // One APB transfer; entered and left just after a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // Request stands until pready is seen high at a rising edge
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r32 = prdata;
    e1 = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    // Idle edge so a following call never drives psel twice at once
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] x, input logic xe);
    apb(1'b0, a, 32'h0);
    check(r32, x);
    check(32'(e1), 32'(xe));
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask

  // Counter advance over k cycles
  task automatic delta(input int k, input int x);
    @(negedge clk);
    c0 = cnt;
    repeat (k) @(negedge clk);
    check({16'h0, cnt - c0}, 32'(x));
    @(posedge clk);
  endtask

  // Hang guard, far above the roughly 1650 cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    complete_run();
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    lvl = 8'h00;
    n_mismatch = 0;
    compares = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdchk(`TSM_SMC_OFF, 32'h0, 1'b0);
    wr(`TSM_SMC_OFF, 32'hffffffff);
    rdchk(`TSM_SMC_OFF, 32'h0ff7, 1'b0);
    check(32'(msm), 32'h1);
    wr(`TSM_SMC_OFF, 32'h70);
    wr(`TSM_SMC_OFF, 32'h0);
    cyc(1);
    check(32'(msm), 32'h0);
    rdchk(12'h010, 32'h0, 1'b1);
    wr(`TSM_CTL_OFF, 32'h1);
    delta(10, 10);
    // Each source alone must reach the trigger; select moved in mode 0 only
    for (int s = 0; s < 8; s++) begin
      wr(`TSM_SMC_OFF, 32'(s << 4));
      lvl <= 8'hff ^ (8'h1 << s);
      cyc(8);
      check(32'(trg), 32'h0);
      lvl <= 8'h1 << s;
      cyc(8);
      check(32'(trg), 32'h1);
      lvl <= 8'h00;
      cyc(8);
    end
    wr(`TSM_SMC_OFF, 32'h0);
    // Reset mode, without and with sync delay
    for (int m = 0; m < 2; m++) begin
      wr(`TSM_SMC_OFF, 32'h4 | 32'(m << 7));
      cyc(5);
      lvl <= 8'h01;
      n = 0;
      do begin
        @(negedge clk);
        n++;
      end while (upd !== 1'b1 && n < 20);
      lat[m] = n;
      check({16'h0, cnt}, 32'h0);
      @(negedge clk);
      check(32'(upd), 32'h0);
      check({16'h0, cnt}, 32'h1);
      @(posedge clk);
      lvl <= 8'h00;
      cyc(3);
    end
    check(32'(lat[1] - lat[0]), 32'h1);
    wr(`TSM_SMC_OFF, 32'h5);
    cyc(4);
    delta(6, 0);
    lvl <= 8'h01;
    cyc(4);
    delta(6, 6);
    lvl <= 8'h00;
    cyc(4);
    delta(6, 0);
    wr(`TSM_CTL_OFF, 32'h0);
    // Trigger mode with sync on, so the start lags one extra clock
    wr(`TSM_SMC_OFF, 32'h86);
    cyc(2);
    check(32'(run), 32'h0);
    lvl <= 8'h01;
    cyc(6);
    check(32'(run), 32'h1);
    lvl <= 8'h00;
    delta(4, 4);
    wr(`TSM_SMC_OFF, 32'h7);
    @(negedge clk);
    c0 = cnt;
    @(posedge clk);
    repeat (4) begin
      lvl <= 8'h01;
      cyc(3);
      lvl <= 8'h00;
      cyc(3);
    end
    @(negedge clk);
    check({16'h0, cnt - c0}, 32'h4);
    @(posedge clk);
    // Forward quadrature then back; net count must return
    for (int m = 1; m < 4; m++) begin
      wr(`TSM_SMC_OFF, 32'(m));
      @(negedge clk);
      c0 = cnt;
      @(posedge clk);
      for (int k = 0; k < 4; k++) begin
        lvl <= fw[k];
        cyc(4);
      end
      @(negedge clk);
      check({16'h0, cnt - c0}, 32'(ex[m]));
      @(posedge clk);
      for (int k = 0; k < 4; k++) begin
        lvl <= bk[k];
        cyc(4);
      end
      @(negedge clk);
      check({16'h0, cnt - c0}, 32'h0);
      @(posedge clk);
    end
    wr(`TSM_SMC_OFF, 32'h0);
    // Filter: glitch refused, level passed only after N samples of DIV
    for (int c = 0; c < 10; c++) begin
      wr(`TSM_SMC_OFF, 32'h70 | 32'(c << 8));
      if (nn[c] > 1) begin
        lvl <= 8'h80;
        @(posedge clk);
        lvl <= 8'h00;
        cyc(12);
        check(32'(fext), 32'h0);
        lvl <= 8'h80;
        cyc((nn[c] - 1) * dv[c]);
        check(32'(fext), 32'h0);
      end
      lvl <= 8'h80;
      cyc(nn[c] * dv[c] + 6);
      check(32'(fext), 32'h1);
      lvl <= 8'h00;
      cyc(nn[c] * dv[c] + 6);
      check(32'(fext), 32'h0);
    end
    // Filter clock divide 2 doubles every sample period of code 1001
    wr(`TSM_CTL_OFF, 32'h100);
    rdchk(`TSM_CTL_OFF, 32'h100, 1'b0);
    lvl <= 8'h80;
    cyc(112);
    check(32'(fext), 32'h0);
    cyc(134);
    check(32'(fext), 32'h1);
    complete_run();
  end
endmodule
`default_nettype wire
